//--- shared/dsw_map.svh
// Constants for the drive status word builder: bit positions, reset values and sizes.
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH

// ************************************************************
// Control word bit positions
// ************************************************************
`define DSW_CW_ON          0
`define DSW_CW_NO_COAST    1
`define DSW_CW_NO_QUICK    2
`define DSW_CW_ENABLE_OP   3
`define DSW_CW_APP_LO      4
`define DSW_CW_FAULT_ACK   7
`define DSW_CW_BUS_CTRL    10
`define DSW_CW_USER_LO     12
`define DSW_CW_USER_HI     15

// ************************************************************
// Status word bit positions
// ************************************************************
`define DSW_SW_RDY_ON      0
`define DSW_SW_RDY_OP      1
`define DSW_SW_OP_EN       2
`define DSW_SW_FAULT       3
`define DSW_SW_NO_COAST    4
`define DSW_SW_NO_QUICK    5
`define DSW_SW_ON_INHIB    6
`define DSW_SW_WARNING     7
`define DSW_SW_AT_SPEED    8
`define DSW_SW_BUS_CTRL    9
`define DSW_SW_FREQ_OK     10
`define DSW_SW_USER_LO     11
`define DSW_SW_USER_HI     15

// ************************************************************
// Sizes and reset values
// ************************************************************
`define DSW_WORD_W         16
`define DSW_USER_SIGS      16
`define DSW_SEL_W          4
`define DSW_STATUS_RESET   16'h0040
`define DSW_CW_RESET       16'h0000

`endif

//--- shared/dsw_pkg.sv
// Types shared by the drive status word builder modules.
package dsw_pkg;

  typedef enum logic [5:0] {
    DSW_ST_INHIBIT  = 6'h01,
    DSW_ST_READY_ON = 6'h02,
    DSW_ST_READY_OP = 6'h04,
    DSW_ST_RUN      = 6'h08,
    DSW_ST_QSTOP    = 6'h10,
    DSW_ST_FAULT    = 6'h20
  } dsw_state_type;

endpackage

//--- shared/dsw_user_if.sv
// Interface carrying user-mapped signal selection between the builder modules.
`timescale 1ns/10ps
`include "dsw_map.svh"
interface dsw_user_if;
  logic [`DSW_USER_SIGS-1:0]  app_sig;
  logic [5*`DSW_SEL_W-1:0]    stat_sel;
  logic [4:0]                 user_bits;

  modport top (output app_sig, output stat_sel, input user_bits);
  modport mux (input app_sig, input stat_sel, output user_bits);
endinterface

//--- verilog/dsw_user_mux.sv
// Selects the five user-defined status bits from application signals.
`timescale 1ns/10ps
`include "dsw_map.svh"
module dsw_user_mux
  import dsw_pkg::*;
(
  dsw_user_if.mux  bus
);

  function automatic logic dsw_pick(input logic [`DSW_USER_SIGS-1:0] sigs,
                                    input logic [`DSW_SEL_W-1:0]     sel);
    dsw_pick = sigs[sel];
  endfunction

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      bus.user_bits[i] = dsw_pick(bus.app_sig, bus.stat_sel[i*`DSW_SEL_W +: `DSW_SEL_W]);
    end
  end

endmodule

//--- verilog/dsw_builder.sv
// Drive state machine and 16-bit drive status word builder.
// ************************************************************
// What this block does
// - Status bit 0 shows ready to switch on.
// - Status bit 1 shows ready to operate.
// - Status bit 2 shows operation enabled.
// - Bit 3 shows any fault, bit 7 shows any warning.
// - Bit 4 is low while coast stop is commanded.
// - Bit 5 is low while quick stop is commanded.
// - Bit 6 high while switching on is inhibited.
// - Bit 8 set when speed matches reference within tolerance.
// - Bit 9 clear when fieldbus commands are ignored for any cause.
// - Bit 10 set while output frequency is within motor limits.
// - Bits 11 to 15 come from configured application signals.
// - Control bits 0 to 3 drive start-up and power-down.
// - Control bits 4 to 10 carry application control functions.
// - Control bits 12 to 15 are configurable by parameters.
// - State changes from control bits 0 to 3 and from faults; status shows state.
// - Simultaneous requests resolve by fixed priority.
// - Control bit 10 high accepts process data, low ignores it.
// - Faults are acknowledged only on a rising edge of bit 7.
// ************************************************************
`timescale 1ns/10ps
`include "dsw_map.svh"
module dsw_builder
  import dsw_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic [`DSW_WORD_W-1:0]     drive_control_word,
  input  wire logic                       fault_present,
  input  wire logic                       warning_present,
  input  wire logic                       speed_at_reference,
  input  wire logic                       freq_within_limits,
  input  wire logic                       panel_local_mode,
  input  wire logic                       tool_has_control,
  input  wire logic                       fieldbus_in_places,
  input  wire logic [`DSW_USER_SIGS-1:0]  app_signals,
  input  wire logic [5*`DSW_SEL_W-1:0]    status_bit_select,
  output logic [`DSW_WORD_W-1:0]          drive_status_word,
  output logic [6:0]                      app_control_bits,
  output logic [3:0]                      user_control_bits,
  output logic                            fault_ack_pulse
);

  // ************************************************************
  // Control acceptance
  // ************************************************************
  logic                    bus_ctrl;
  logic [`DSW_WORD_W-1:0]  held_cw_ff;
  logic [`DSW_WORD_W-1:0]  nxt_held_cw;
  logic [`DSW_WORD_W-1:0]  cw;
  logic                    ack_bit_ff;
  logic                    fault_ff;
  logic                    ack_rise;

  // The fieldbus is ignored for any of the four causes.
  function automatic logic dsw_accept(input logic take_bit,
                                      input logic local_mode,
                                      input logic tool_ctrl,
                                      input logic bus_place);
    dsw_accept = take_bit & ~local_mode & ~tool_ctrl & bus_place;
  endfunction

  // Holding the last word rather than clearing it means a handover to local control
  // does not by itself stop the drive; the local place must command the stop.
  assign bus_ctrl = dsw_accept(drive_control_word[`DSW_CW_BUS_CTRL], panel_local_mode,
                               tool_has_control, fieldbus_in_places);

  // While process data is ignored the last accepted word stays in force.
  assign nxt_held_cw = bus_ctrl ? drive_control_word : held_cw_ff;
  assign cw = nxt_held_cw;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      held_cw_ff <= `DSW_CW_RESET;
    end else begin
      held_cw_ff <= nxt_held_cw;
    end
  end

  // ************************************************************
  // Fault acknowledge edge
  // ************************************************************
  // A level held high never acknowledges twice.
  function automatic logic dsw_rise(input logic now_level, input logic last_level);
    dsw_rise = now_level & ~last_level;
  endfunction

  // The edge is taken on the accepted word, so a refused telegram cannot acknowledge.
  assign ack_rise = dsw_rise(cw[`DSW_CW_FAULT_ACK], ack_bit_ff);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_bit_ff <= 1'b0;
    end else begin
      ack_bit_ff <= cw[`DSW_CW_FAULT_ACK];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_ack_pulse <= 1'b0;
    end else begin
      fault_ack_pulse <= ack_rise;
    end
  end

  // A new fault wins over an acknowledge in the same cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_ff <= 1'b0;
    end else if (fault_present) begin
      fault_ff <= 1'b1;
    end else if (ack_rise) begin
      fault_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Drive state machine
  // ************************************************************
  dsw_state_type state_ff;
  dsw_state_type nxt_state;
  logic          on_cmd;
  logic          coast_cmd;
  logic          quick_cmd;
  logic          enable_cmd;

  assign on_cmd     = cw[`DSW_CW_ON];
  assign coast_cmd  = ~cw[`DSW_CW_NO_COAST];
  assign quick_cmd  = ~cw[`DSW_CW_NO_QUICK];
  assign enable_cmd = cw[`DSW_CW_ENABLE_OP];

  // Either stop request drops a ready drive back to inhibit.
  function automatic logic dsw_stop_req(input logic coast_req, input logic quick_req);
    dsw_stop_req = coast_req | quick_req;
  endfunction

  // Priority: fault, then coast stop, then quick stop, then off, then enable.
  always_comb begin
    nxt_state = state_ff;
    if (fault_ff) begin
      nxt_state = DSW_ST_FAULT;
    end else begin
      case (state_ff)
        DSW_ST_FAULT: begin
          nxt_state = DSW_ST_INHIBIT;
        end
        DSW_ST_INHIBIT: begin
          // Switching on needs off, no coast and no quick stop first.
          if (!on_cmd && !coast_cmd && !quick_cmd) begin
            nxt_state = DSW_ST_READY_ON;
          end
        end
        DSW_ST_READY_ON: begin
          if (dsw_stop_req(coast_cmd, quick_cmd)) begin
            nxt_state = DSW_ST_INHIBIT;
          end else if (on_cmd) begin
            nxt_state = DSW_ST_READY_OP;
          end
        end
        DSW_ST_READY_OP: begin
          if (dsw_stop_req(coast_cmd, quick_cmd)) begin
            nxt_state = DSW_ST_INHIBIT;
          end else if (!on_cmd) begin
            nxt_state = DSW_ST_READY_ON;
          end else if (enable_cmd) begin
            nxt_state = DSW_ST_RUN;
          end
        end
        DSW_ST_RUN: begin
          if (coast_cmd) begin
            nxt_state = DSW_ST_INHIBIT;
          end else if (quick_cmd) begin
            nxt_state = DSW_ST_QSTOP;
          end else if (!on_cmd) begin
            nxt_state = DSW_ST_READY_ON;
          end else if (!enable_cmd) begin
            nxt_state = DSW_ST_READY_OP;
          end
        end
        DSW_ST_QSTOP: begin
          // Quick stop ends in inhibit once the command is released.
          if (coast_cmd || !quick_cmd) begin
            nxt_state = DSW_ST_INHIBIT;
          end
        end
        default: begin
          nxt_state = DSW_ST_INHIBIT;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= DSW_ST_INHIBIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // Application and user control outputs
  // ************************************************************
  // Bits 10 to 4 are passed on as accepted, with no interpretation here.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      app_control_bits <= 7'h00;
    end else begin
      app_control_bits <= cw[`DSW_CW_BUS_CTRL:`DSW_CW_APP_LO];
    end
  end

  // Bits 15 to 12 get their meaning from the parameter mapping downstream.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      user_control_bits <= 4'h0;
    end else begin
      user_control_bits <= cw[`DSW_CW_USER_HI:`DSW_CW_USER_LO];
    end
  end

  // ************************************************************
  // User status bit selection
  // ************************************************************
  dsw_user_if user_if ();

  assign user_if.app_sig  = app_signals;
  assign user_if.stat_sel = status_bit_select;

  dsw_user_mux u_user_mux (
    .bus (user_if.mux)
  );

  // ************************************************************
  // State decoding
  // ************************************************************
  // Every status bit that reports the state reads through one of these functions, so
  // the word and the state machine cannot drift apart when a state is added.

  // Ready to switch on holds in ready on, ready to operate and run, but not in quick stop or fault.
  function automatic logic dsw_is_ready_on(input dsw_state_type st);
    dsw_is_ready_on = (st == DSW_ST_READY_ON) || (st == DSW_ST_READY_OP)
                      || (st == DSW_ST_RUN);
  endfunction

  // Ready to operate holds once the drive is switched on.
  function automatic logic dsw_is_ready_op(input dsw_state_type st);
    dsw_is_ready_op = (st == DSW_ST_READY_OP) || (st == DSW_ST_RUN);
  endfunction

  // Quick stop is not counted as running, so the enabled bit drops at once.
  function automatic logic dsw_is_running(input dsw_state_type st);
    dsw_is_running = (st == DSW_ST_RUN);
  endfunction

  // A drive in fault cannot be switched on until the fault is acknowledged.
  function automatic logic dsw_is_inhibited(input dsw_state_type st);
    dsw_is_inhibited = (st == DSW_ST_INHIBIT) || (st == DSW_ST_FAULT);
  endfunction

  // ************************************************************
  // Status word assembly
  // ************************************************************
  logic [`DSW_WORD_W-1:0] nxt_status;

  always_comb begin
    nxt_status = '0;
    nxt_status[`DSW_SW_RDY_ON]   = dsw_is_ready_on(state_ff);
    nxt_status[`DSW_SW_RDY_OP]   = dsw_is_ready_op(state_ff);
    nxt_status[`DSW_SW_OP_EN]    = dsw_is_running(state_ff);
    nxt_status[`DSW_SW_FAULT]    = fault_ff;
    nxt_status[`DSW_SW_NO_COAST] = ~coast_cmd;
    nxt_status[`DSW_SW_NO_QUICK] = ~quick_cmd;
    nxt_status[`DSW_SW_ON_INHIB] = dsw_is_inhibited(state_ff);
    nxt_status[`DSW_SW_WARNING]  = warning_present;
    nxt_status[`DSW_SW_AT_SPEED] = speed_at_reference;
    nxt_status[`DSW_SW_BUS_CTRL] = bus_ctrl;
    nxt_status[`DSW_SW_FREQ_OK]  = freq_within_limits;
    nxt_status[`DSW_SW_USER_HI:`DSW_SW_USER_LO] = user_if.user_bits;
  end

  // ************************************************************
  // Status word registers
  // ************************************************************
  // The word is kept as four fields, one register per concern. All of them load on
  // the same edge, so a fieldbus read still sees one consistent cycle.
  localparam logic [`DSW_WORD_W-1:0] STATUS_RESET = `DSW_STATUS_RESET;

  logic [`DSW_SW_OP_EN:`DSW_SW_RDY_ON]      sw_state_ff;
  logic [`DSW_SW_WARNING:`DSW_SW_FAULT]     sw_cond_ff;
  logic [`DSW_SW_FREQ_OK:`DSW_SW_AT_SPEED]  sw_mon_ff;
  logic [`DSW_SW_USER_HI:`DSW_SW_USER_LO]   sw_user_ff;

  // Ready and enabled bits, one edge behind the state register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_state_ff <= STATUS_RESET[`DSW_SW_OP_EN:`DSW_SW_RDY_ON];
    end else begin
      sw_state_ff <= nxt_status[`DSW_SW_OP_EN:`DSW_SW_RDY_ON];
    end
  end

  // Fault, stop, inhibit and warning bits.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_cond_ff <= STATUS_RESET[`DSW_SW_WARNING:`DSW_SW_FAULT];
    end else begin
      sw_cond_ff <= nxt_status[`DSW_SW_WARNING:`DSW_SW_FAULT];
    end
  end

  // Speed match, bus control and frequency limit bits follow their inputs with no
  // filtering, so a chattering monitor shows up here unchanged.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_mon_ff <= STATUS_RESET[`DSW_SW_FREQ_OK:`DSW_SW_AT_SPEED];
    end else begin
      sw_mon_ff <= nxt_status[`DSW_SW_FREQ_OK:`DSW_SW_AT_SPEED];
    end
  end

  // A change of the select fields shows on the next edge, never half way.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_user_ff <= STATUS_RESET[`DSW_SW_USER_HI:`DSW_SW_USER_LO];
    end else begin
      sw_user_ff <= nxt_status[`DSW_SW_USER_HI:`DSW_SW_USER_LO];
    end
  end

  assign drive_status_word = {sw_user_ff, sw_mon_ff, sw_cond_ff, sw_state_ff};

endmodule

//--- verification/dsw_builder_props.sv
// Port-level checker of the drive status word builder.
`timescale 1ns/10ps
module dsw_builder_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [15:0] drive_control_word,
  input wire logic        fault_present,
  input wire logic        warning_present,
  input wire logic        speed_at_reference,
  input wire logic        freq_within_limits,
  input wire logic        panel_local_mode,
  input wire logic        tool_has_control,
  input wire logic        fieldbus_in_places,
  input wire logic [15:0] app_signals,
  input wire logic [19:0] status_bit_select,
  input wire logic [15:0] drive_status_word,
  input wire logic        fault_ack_pulse
);
  // ********************
  // Properties
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [15:0] cw  = drive_control_word;
  wire [15:0] sw  = drive_status_word;
  wire        acc = cw[10] & ~panel_local_mode & ~tool_has_control & fieldbus_in_places;
  wire        ack_in = cw[7];
  wire        en_in  = cw[3];
  wire [1:0]  lim    = {freq_within_limits, speed_at_reference};
  wire        usr0   = app_signals[status_bit_select[3:0]];
  // Stops are held two edges so state and status have both caught up.
  sequence s_coast; (acc && !cw[1]) [*2]; endsequence
  sequence s_quick; (acc && cw[1] && !cw[2]) [*2]; endsequence
  property p_coast; s_coast |=> !sw[4] && !sw[2]; endproperty
  property p_quick; s_quick |=> !sw[5]; endproperty
  property p_enable; $rose(sw[2]) |-> $past(en_in, 2); endproperty
  property p_inhibit; sw[6] |-> sw[2:0] == 3'b000; endproperty
  // The fault reaches the latch, then the state, then the word: three edges.
  property p_fault; fault_present [*3] |=> sw[3] && !sw[2]; endproperty
  property p_warn; 1 |=> sw[7] == $past(warning_present); endproperty
  property p_bus; 1 |=> sw[9] == $past(acc); endproperty
  property p_limits; 1 |=> {sw[10], sw[8]} == $past(lim); endproperty
  property p_user; 1 |=> sw[11] == $past(usr0); endproperty
  property p_ack; fault_ack_pulse |-> ($past(ack_in) || $past(ack_in, 2)) ##1 !fault_ack_pulse;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop not shown");
  a_quick: assert property (p_quick) else $error("quick stop not shown");
  a_enable: assert property (p_enable) else $error("enable without request");
  a_inhibit: assert property (p_inhibit) else $error("inhibit with ready bits");
  a_fault: assert property (p_fault) else $error("fault not shown");
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  a_bus: assert property (p_bus) else $error("bus control bit wrong");
  a_limits: assert property (p_limits) else $error("speed or limit bit wrong");
  a_user: assert property (p_user) else $error("user bit wrong");
  a_ack: assert property (p_ack) else $error("ack pulse wrong");
endmodule

bind dsw_builder dsw_builder_props u_props (.*);

//--- verification/dsw_fieldbus_model.sv
// Fieldbus controller model that presents the control word to the drive.
`timescale 1ns/10ps
module dsw_fieldbus_model (
  input  wire logic        clock,
  input  wire logic [15:0] plc_word,
  output logic      [15:0] drive_control_word = 16'h0000
);
  // ********************
  // Telegram output
  // ********************
  // Updating on the falling edge keeps the word settled at every drive sampling edge.
  always @(negedge clock) begin
    drive_control_word <= plc_word;
  end
endmodule

//--- verification/test_dsw_builder.sv
// Self-checking testbench of the drive status word builder.
`timescale 1ns/10ps
module test_dsw_builder;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] plc_word = 16'h0000;
  logic [15:0] cw;
  logic        flt = 1'b0, warn = 1'b0, spd = 1'b0, frq = 1'b0;
  logic        loc = 1'b0, tool = 1'b0, plc = 1'b1;
  logic [15:0] app = 16'h0000;
  logic [19:0] sel = 20'h00000;
  logic [15:0] sw;
  logic [6:0]  acb;
  logic [3:0]  ucb;
  logic        ack;
  int          n_fail = 0, samples_checked = 0, cycles = 0, n_pulse = 0;
  // ********************
  // Harness
  // ********************
  initial begin
    forever #4 clock = ~clock;
  end
  dsw_fieldbus_model u_plc (.clock(clock), .plc_word(plc_word), .drive_control_word(cw));
  dsw_builder u_dut (.clock(clock), .resetn(resetn), .drive_control_word(cw),
    .fault_present(flt), .warning_present(warn), .speed_at_reference(spd),
    .freq_within_limits(frq), .panel_local_mode(loc), .tool_has_control(tool),
    .fieldbus_in_places(plc), .app_signals(app), .status_bit_select(sel),
    .drive_status_word(sw), .app_control_bits(acb), .user_control_bits(ucb),
    .fault_ack_pulse(ack));
  always @(negedge clock) begin
    n_pulse += (ack === 1'b1);
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  // The word leaves the controller at the next falling edge; state and status follow.
  task automatic cmd(logic [15:0] w);
    @(posedge clock);
    plc_word = w;
    cyc(4);
  endtask
  task automatic run_up();
    cmd(16'h0400);
    cmd(16'h0406);
    cmd(16'h0407);
    cmd(16'h040f);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_start();
    cmd(16'h0400);
    chk("inhibit", sw & 16'h0277, 16'h0240);
    cmd(16'h0406);
    chk("ready on", sw & 16'h0277, 16'h0231);
    cmd(16'h0407);
    chk("ready op", sw & 16'h0046, 16'h0002);
    cmd(16'h040f);
    chk("running", sw & 16'h0044, 16'h0004);
  endtask
  task automatic t_stops();
    cmd(16'h040b);
    chk("quick stop", sw & 16'h0024, 16'h0000);
    run_up();
    cmd(16'h040d);
    chk("coast stop", sw & 16'h0054, 16'h0040);
  endtask
  task automatic t_fault();
    run_up();
    flt = 1'b1;
    cyc(3);
    chk("fault", sw & 16'h000c, 16'h0008);
    flt = 1'b0;
    cmd(16'h040f);
    chk("fault held", sw & 16'h0008, 16'h0008);
    n_pulse = 0;
    cmd(16'h0480);
    chk("ack pulses", n_pulse[15:0], 16'h0001);
    chk("fault cleared", sw & 16'h0048, 16'h0040);
    cmd(16'h0480);
    chk("steady ack", n_pulse[15:0], 16'h0001);
  endtask
  task automatic t_flags();
    {warn, spd, frq} = 3'b111;
    cyc(3);
    chk("flags on", sw & 16'h0580, 16'h0580);
    {warn, spd, frq} = 3'b000;
    cyc(3);
    chk("flags off", sw & 16'h0580, 16'h0000);
  endtask
  // Each of the four causes of ignoring the fieldbus in turn must freeze the accepted word.
  task automatic t_bus();
    for (int i = 0; i < 4; i++) begin
      cmd(16'h5400);
      {loc, tool, plc} = {i == 1, i == 2, i != 3};
      cmd(i == 0 ? 16'ha3f0 : 16'ha7f0);
      chk("refused", {4'h0, acb, ucb, sw[9]}, {4'h0, 7'h40, 4'h5, 1'b0});
      {loc, tool, plc} = 3'b001;
      cmd(16'ha7f0);
      chk("accepted", {4'h0, acb, ucb, sw[9]}, {4'h0, 7'h7f, 4'ha, 1'b1});
    end
  endtask
  task automatic t_user();
    sel = {4'hf, 4'h9, 4'h4, 4'h2, 4'h0};
    app = 16'h8214;
    cyc(3);
    chk("user bits", sw & 16'hf800, 16'hf000);
    app = ~16'h8214;
    cyc(3);
    chk("user bits", sw & 16'hf800, 16'h0800);
  endtask
  initial begin
    cyc(10);
    chk("reset word", sw, 16'h0040);
    chk("reset outputs", {4'h0, acb, ucb, ack}, 16'h0000);
    resetn = 1'b1;
    t_start();
    t_stops();
    t_fault();
    t_flags();
    t_bus();
    t_user();
    conclude();
  end
endmodule
